//--- core/dsrp_pkg.sv
package dsrp_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int TIMEOUT_MS = 20;
    localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

    localparam logic [7:0] SPI_RD_ID = 8'h58;
    localparam logic [7:0] SPI_WR_ID = 8'hA8;
    localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
    localparam logic [5:0] SPI_LAST_BIT = 6'h2F;
    localparam logic [5:0] SOFT_RESET_ONES = 6'h2F;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [2:0] SPI_ID_BYTE = 3'h0;
    localparam logic [2:0] SPI_ADDR_BYTE = 3'h1;
    localparam logic [2:0] SPI_SUM_BYTE = 3'h5;
    localparam logic [5:0] SPI_DATA_START = 6'h10;

    localparam logic [5:0] UART_WR_PAT = 6'h2A;
    localparam logic [5:0] UART_RD_PAT = 6'h16;
    localparam logic [7:0] BULK_ADDR = 8'hAA;
    localparam logic [7:0] BULK_HEAD = 8'h55;
    localparam logic [2:0] BULK_LAST_FIELD = 3'h6;
    localparam logic [1:0] DATA_BYTES = 2'h3;
    localparam logic [1:0] LAST_WR_BYTE = 2'h2;
    localparam int ZERO_RUN_BITS = 33;

    localparam logic [7:0] MODE_ADDR = 8'h19;
    localparam logic [23:0] MODE_RESET = 24'h00_0000;
    localparam int BAUD_LSB = 8;

    localparam logic [15:0] DIV_4800 = 16'(CLK_HZ / 4800);
    localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / 9600);
    localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / 19200);
    localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / 38400);

    typedef enum logic [2:0] {
        U_IDLE = 3'b000,
        U_ADDR = 3'b001,
        U_WDATA = 3'b010,
        U_WSUM = 3'b011,
        U_HEAD = 3'b100,
        U_FETCH = 3'b101,
        U_SEND = 3'b110
    } dsrp_ustate_t;

    function automatic logic [7:0] csum8(input logic [7:0] base, input logic [23:0] d);
        csum8 = ~(base + d[7:0] + d[15:8] + d[23:16]);
    endfunction

    function automatic logic [15:0] baud_div(input logic [1:0] rate, input logic strap);
        case (rate)
            2'h2: baud_div = DIV_19200;
            2'h3: baud_div = DIV_38400;
            default: baud_div = strap ? DIV_9600 : DIV_4800;
        endcase
    endfunction

    function automatic logic [7:0] bulk_addr(input logic [2:0] field);
        case (field)
            3'h0: bulk_addr = 8'h03;
            3'h1: bulk_addr = 8'h04;
            3'h2: bulk_addr = 8'h05;
            3'h3: bulk_addr = 8'h06;
            3'h4: bulk_addr = 8'h07;
            3'h5: bulk_addr = 8'h08;
            default: bulk_addr = 8'h09;
        endcase
    endfunction

endpackage

//--- core/dsrp_uart_phy.sv
`timescale 1ns/1ps
`default_nettype none
module dsrp_uart_phy (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] div,
    input wire logic rxd,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic zero_rst,
    input wire logic tx_start,
    input wire logic [7:0] tx_byte,
    output logic txd,
    output logic tx_busy
);
    import dsrp_pkg::*;

    logic rx_run_reg;
    logic rx_arm_reg;
    logic [15:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [23:0] low_cnt_reg;
    logic [9:0] tx_sh_reg;
    logic [15:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [23:0] zero_limit;

    assign zero_limit = 24'(ZERO_RUN_BITS) * {8'h00, div};

    // A held-low line must rise again before a new start bit is believed.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            low_cnt_reg <= '0;
            zero_rst <= 1'b0;
        end else begin
            low_cnt_reg <= rxd ? '0 : low_cnt_reg + 24'h1;
            zero_rst <= !rxd && (low_cnt_reg == zero_limit);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || zero_rst) begin
            rx_run_reg <= 1'b0;
            rx_arm_reg <= 1'b0;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_byte <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (rxd) begin
                rx_arm_reg <= 1'b1;
            end
            if (!rx_run_reg) begin
                if (!rxd && rx_arm_reg) begin
                    rx_run_reg <= 1'b1;
                    rx_cnt_reg <= {1'b0, div[15:1]};
                    rx_bit_reg <= '0;
                end
            end else if (rx_cnt_reg != '0) begin
                rx_cnt_reg <= rx_cnt_reg - 16'h1;
            end else begin
                rx_cnt_reg <= div - 16'h1;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h0 && rxd) begin
                    rx_run_reg <= 1'b0;
                end else if (rx_bit_reg != 4'h0 && rx_bit_reg <= 4'h8) begin
                    rx_byte <= {rxd, rx_byte[7:1]};
                end else if (rx_bit_reg == 4'h9) begin
                    rx_run_reg <= 1'b0;
                    rx_valid <= rxd;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_sh_reg <= '1;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_busy <= 1'b0;
        end else if (!tx_busy) begin
            if (tx_start) begin
                tx_sh_reg <= {1'b1, tx_byte, 1'b0};
                tx_cnt_reg <= div - 16'h1;
                tx_bit_reg <= '0;
                tx_busy <= 1'b1;
            end
        end else if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h1;
        end else begin
            tx_cnt_reg <= div - 16'h1;
            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_busy <= (tx_bit_reg != 4'h9);
        end
    end

    assign txd = tx_sh_reg[0];

endmodule
`default_nettype wire

//--- core/dsrp_port.sv
// Contract
// - Register values always travel as three bytes.
// - Select strap high means SPI, low UART.
// - SPI bytes MSB first, half duplex slave.
// - SPI mode 1: sample falling, shift rising.
// - Shared pin is low-active select or tied low.
// - SPI frame: id, address, three data, checksum.
// - SPI data bytes go high byte first.
// - SPI checksum is inverted low sum byte.
// - Read shifts out after address, released last fall.
// - After each frame wait for new id.
// - Six 0xFF bytes reset SPI logic alone.
// - UART 8N1, half duplex slave.
// - Baud from mode bits and baud strap.
// - Baud field clears to zero at reset.
// - UART read replies three bytes then checksum.
// - UART checksum is inverted low sum byte.
// - Command address bits must match address straps.
// - Address 0xAA read returns header-led bulk packet.
// - Bulk checksum covers command, header and data.
// - Receiver resets after gap beyond 20 ms.
// - Over 32 zero bits resets the receiver.
// - Bad id or checksum discards whole frame; SPI reads issue at the address byte, checksum unchecked.
`timescale 1ns/1ps
`default_nettype none
module dsrp_port #(
    parameter int TIMEOUT = dsrp_pkg::TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic interface_select_strap,
    input wire logic sclk_or_baud_strap,
    input wire logic rx_or_sdi,
    input wire logic address_high_or_chip_select,
    input wire logic address_low_strap,
    output logic tx_or_sdo_out,
    output logic tx_or_sdo_oe,
    output logic [7:0] reg_addr,
    output logic [23:0] reg_wr_data,
    output logic reg_wr_strobe,
    output logic reg_rd_strobe,
    input wire logic [23:0] reg_rd_data
);
    import dsrp_pkg::*;

    localparam int GAP_W = $clog2(TIMEOUT + 1);

    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic sclk_d_reg;
    logic sel_s, sclk_s, sdi_s, ncs_s, a1_s;
    logic spi_rise, spi_fall;

    logic [23:0] mode_reg;
    logic [23:0] rd_data;
    logic rd_done;

    logic [5:0] spi_bit_reg;
    logic [6:0] spi_sh_reg;
    logic [5:0] spi_ones_reg;
    logic [7:0] spi_id_reg;
    logic [7:0] spi_addr_reg;
    logic [7:0] spi_sum_reg;
    logic [23:0] spi_wdata_reg;
    logic [31:0] spi_tx_reg;
    logic spi_sdo_reg, spi_oe_reg;
    logic spi_rd_go_reg, spi_wr_go_reg;
    logic [7:0] spi_byte;
    logic spi_soft_rst;

    dsrp_ustate_t u_state_reg;
    logic [7:0] u_cmd_reg, u_addr_reg, u_sum_reg, u_tx_byte_reg, u_rd_addr_reg;
    logic [23:0] u_data_reg;
    logic [1:0] u_cnt_reg;
    logic [2:0] u_fld_reg;
    logic u_bulk_reg, u_tx_start_reg, u_rd_go_reg, u_wr_go_reg;
    logic [GAP_W-1:0] gap_reg;
    logic gap_hit;
    logic [7:0] rx_byte;
    logic rx_valid, zero_rst, u_txd, tx_busy, tx_free;

    // Every strap and the link clock pass two flip-flops before use.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sclk_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {interface_select_strap, sclk_or_baud_strap, rx_or_sdi,
                          address_high_or_chip_select, address_low_strap};
            sync2_reg <= sync1_reg;
            sclk_d_reg <= sync2_reg[3];
        end
    end

    assign {sel_s, sclk_s, sdi_s, ncs_s, a1_s} = sync2_reg;
    assign spi_rise = sclk_s && !sclk_d_reg;
    assign spi_fall = !sclk_s && sclk_d_reg;
    assign spi_byte = {spi_sh_reg, sdi_s};
    assign spi_soft_rst = spi_fall && sdi_s && spi_ones_reg == SOFT_RESET_ONES;

    // Register port shared by both links; only the selected one ever issues.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_addr <= '0;
            reg_wr_data <= '0;
            reg_wr_strobe <= 1'b0;
            reg_rd_strobe <= 1'b0;
            mode_reg <= MODE_RESET;
        end else begin
            reg_rd_strobe <= sel_s ? spi_rd_go_reg : u_rd_go_reg;
            reg_wr_strobe <= sel_s ? spi_wr_go_reg : u_wr_go_reg;
            if (spi_rd_go_reg || spi_wr_go_reg) begin
                reg_addr <= spi_addr_reg;
                reg_wr_data <= spi_wdata_reg;
            end else if (u_rd_go_reg) begin
                reg_addr <= u_rd_addr_reg;
            end else if (u_wr_go_reg) begin
                reg_addr <= u_addr_reg;
                reg_wr_data <= u_data_reg;
            end
            if (reg_wr_strobe && reg_addr == MODE_ADDR) begin
                mode_reg <= reg_wr_data;
            end
        end
    end

    assign rd_done = reg_rd_strobe;
    assign rd_data = (reg_addr == MODE_ADDR) ? mode_reg : reg_rd_data;

    // SPI slave. The select pin, when high, holds the frame at its start.
    always_ff @(posedge core_clk) begin
        if (reset || !sel_s || ncs_s || spi_soft_rst) begin
            spi_bit_reg <= '0;
            spi_sh_reg <= '0;
            spi_ones_reg <= '0;
            spi_id_reg <= '0;
            spi_addr_reg <= '0;
            spi_sum_reg <= '0;
            spi_wdata_reg <= '0;
            spi_tx_reg <= '0;
            spi_sdo_reg <= 1'b0;
            spi_oe_reg <= 1'b0;
            spi_rd_go_reg <= 1'b0;
            spi_wr_go_reg <= 1'b0;
        end else begin
            spi_rd_go_reg <= 1'b0;
            spi_wr_go_reg <= 1'b0;
            if (rd_done && spi_id_reg == SPI_RD_ID) begin
                spi_tx_reg <= {rd_data, csum8(spi_sum_reg, rd_data)};
            end
            if (spi_fall) begin
                spi_sh_reg <= spi_byte[6:0];
                spi_ones_reg <= sdi_s ? spi_ones_reg + 6'h1 : '0;
                spi_bit_reg <= spi_bit_reg + 6'h1;
                if (spi_bit_reg[2:0] == BYTE_LAST_BIT) begin
                    case (spi_bit_reg[5:3])
                        SPI_ID_BYTE: begin
                            spi_id_reg <= spi_byte;
                            spi_sum_reg <= spi_byte;
                        end
                        SPI_ADDR_BYTE: begin
                            spi_addr_reg <= spi_byte;
                            spi_sum_reg <= spi_sum_reg + spi_byte;
                            spi_rd_go_reg <= (spi_id_reg == SPI_RD_ID);
                        end
                        SPI_SUM_BYTE: begin
                            spi_wr_go_reg <= spi_id_reg == SPI_WR_ID &&
                                csum8(spi_sum_reg, spi_wdata_reg) == spi_byte;
                        end
                        default: begin
                            spi_wdata_reg <= {spi_wdata_reg[15:0], spi_byte};
                        end
                    endcase
                end
                if (spi_bit_reg == SPI_LAST_BIT) begin
                    spi_bit_reg <= '0;
                    spi_oe_reg <= 1'b0;
                end
            end
            if (spi_rise && spi_id_reg == SPI_RD_ID && spi_bit_reg >= SPI_DATA_START) begin
                spi_sdo_reg <= spi_tx_reg[31];
                spi_tx_reg <= {spi_tx_reg[30:0], 1'b0};
                spi_oe_reg <= 1'b1;
            end
        end
    end

    dsrp_uart_phy u_phy (
        .core_clk(core_clk),
        .reset(reset || sel_s),
        .div(baud_div(mode_reg[BAUD_LSB+1:BAUD_LSB], sclk_s)),
        .rxd(sdi_s),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .zero_rst(zero_rst),
        .tx_start(u_tx_start_reg),
        .tx_byte(u_tx_byte_reg),
        .txd(u_txd),
        .tx_busy(tx_busy)
    );

    assign tx_free = !tx_busy && !u_tx_start_reg;

    // The gap clock only runs while a host frame is half received.
    always_ff @(posedge core_clk) begin
        if (reset || rx_valid || gap_hit || u_state_reg == U_IDLE || u_state_reg >= U_HEAD) begin
            gap_reg <= '0;
        end else begin
            gap_reg <= gap_reg + GAP_W'(1);
        end
    end

    assign gap_hit = (gap_reg == GAP_W'(TIMEOUT));

    always_ff @(posedge core_clk) begin
        if (reset || sel_s || zero_rst || gap_hit) begin
            u_state_reg <= U_IDLE;
            u_cmd_reg <= '0;
            u_addr_reg <= '0;
            u_sum_reg <= '0;
            u_data_reg <= '0;
            u_cnt_reg <= '0;
            u_fld_reg <= '0;
            u_bulk_reg <= 1'b0;
            u_tx_start_reg <= 1'b0;
            u_tx_byte_reg <= '0;
            u_rd_addr_reg <= '0;
            u_rd_go_reg <= 1'b0;
            u_wr_go_reg <= 1'b0;
        end else begin
            u_tx_start_reg <= 1'b0;
            u_rd_go_reg <= 1'b0;
            u_wr_go_reg <= 1'b0;
            case (u_state_reg)
                U_IDLE: begin
                    if (rx_valid && rx_byte[1:0] == {ncs_s, a1_s} &&
                        (rx_byte[7:2] == UART_WR_PAT || rx_byte[7:2] == UART_RD_PAT)) begin
                        u_cmd_reg <= rx_byte;
                        u_sum_reg <= rx_byte;
                        u_state_reg <= U_ADDR;
                    end
                end
                U_ADDR: begin
                    if (rx_valid) begin
                        u_addr_reg <= rx_byte;
                        u_cnt_reg <= '0;
                        u_fld_reg <= '0;
                        u_bulk_reg <= 1'b0;
                        u_sum_reg <= u_sum_reg + rx_byte;
                        if (u_cmd_reg[7:2] == UART_WR_PAT) begin
                            u_state_reg <= U_WDATA;
                        end else if (rx_byte == BULK_ADDR) begin
                            u_bulk_reg <= 1'b1;
                            u_sum_reg <= u_sum_reg + BULK_HEAD;
                            u_state_reg <= U_HEAD;
                        end else begin
                            u_rd_addr_reg <= rx_byte;
                            u_rd_go_reg <= 1'b1;
                            u_state_reg <= U_FETCH;
                        end
                    end
                end
                U_WDATA: begin
                    if (rx_valid) begin
                        u_data_reg <= {rx_byte, u_data_reg[23:8]};
                        u_sum_reg <= u_sum_reg + rx_byte;
                        u_cnt_reg <= u_cnt_reg + 2'h1;
                        if (u_cnt_reg == LAST_WR_BYTE) begin
                            u_state_reg <= U_WSUM;
                        end
                    end
                end
                U_WSUM: begin
                    if (rx_valid) begin
                        u_wr_go_reg <= (~u_sum_reg == rx_byte);
                        u_state_reg <= U_IDLE;
                    end
                end
                U_HEAD: begin
                    if (tx_free) begin
                        u_tx_start_reg <= 1'b1;
                        u_tx_byte_reg <= BULK_HEAD;
                        u_rd_addr_reg <= bulk_addr(u_fld_reg);
                        u_rd_go_reg <= 1'b1;
                        u_state_reg <= U_FETCH;
                    end
                end
                U_FETCH: begin
                    if (rd_done) begin
                        u_data_reg <= rd_data;
                        u_cnt_reg <= '0;
                        u_state_reg <= U_SEND;
                    end
                end
                U_SEND: begin
                    if (tx_free) begin
                        if (u_cnt_reg != DATA_BYTES) begin
                            u_tx_start_reg <= 1'b1;
                            u_tx_byte_reg <= u_data_reg[7:0];
                            u_data_reg <= {8'h00, u_data_reg[23:8]};
                            u_sum_reg <= u_sum_reg + u_data_reg[7:0];
                            u_cnt_reg <= u_cnt_reg + 2'h1;
                        end else if (u_bulk_reg && u_fld_reg != BULK_LAST_FIELD) begin
                            u_fld_reg <= u_fld_reg + 3'h1;
                            u_rd_addr_reg <= bulk_addr(u_fld_reg + 3'h1);
                            u_rd_go_reg <= 1'b1;
                            u_state_reg <= U_FETCH;
                        end else begin
                            u_tx_start_reg <= 1'b1;
                            u_tx_byte_reg <= ~u_sum_reg;
                            u_state_reg <= U_IDLE;
                        end
                    end
                end
                default: begin
                    u_state_reg <= U_IDLE;
                end
            endcase
        end
    end

    // UART transmit is push-pull, so the pin is driven whenever UART owns it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_or_sdo_out <= 1'b1;
            tx_or_sdo_oe <= 1'b0;
        end else begin
            tx_or_sdo_out <= sel_s ? spi_sdo_reg : u_txd;
            tx_or_sdo_oe <= sel_s ? spi_oe_reg : 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence spi_last_fall_s;
        sel_s && !ncs_s && spi_fall && spi_bit_reg == SPI_LAST_BIT;
    endsequence

    sequence bad_uart_sum_s;
        u_state_reg == U_WSUM && rx_valid && ~u_sum_reg != rx_byte;
    endsequence

    spi_release_a: assert property (spi_last_fall_s |=> !spi_oe_reg ##2 !tx_or_sdo_oe)
        else $error("SDO still driven after the last falling edge.");
    spi_frame_wrap_a: assert property (spi_last_fall_s |=> spi_bit_reg == '0)
        else $error("SPI frame did not return to the id byte.");
    soft_reset_a: assert property (spi_soft_rst |=> spi_bit_reg == '0 && spi_ones_reg == '0)
        else $error("Six all-ones bytes did not reset the SPI logic.");
    spi_write_id_a: assert property (spi_wr_go_reg |-> spi_id_reg == SPI_WR_ID ##1 reg_wr_strobe)
        else $error("SPI write issued without the write id.");
    baud_clear_a: assert property (disable iff (1'b0) reset |=> mode_reg[BAUD_LSB+1:BAUD_LSB] == 2'h0)
        else $error("Baud field not cleared by reset.");
    uart_timeout_a: assert property (gap_hit |=> u_state_reg == U_IDLE && gap_reg == '0)
        else $error("Receiver did not reset after the gap.");
    zero_run_a: assert property (zero_rst |=> u_state_reg == U_IDLE)
        else $error("Zero run did not reset the receiver.");
    uart_discard_a: assert property (bad_uart_sum_s |=> !u_wr_go_reg ##1 !reg_wr_strobe)
        else $error("Frame with bad checksum was written.");
    uart_addr_match_a: assert property (u_wr_go_reg |-> u_cmd_reg[1:0] == {ncs_s, a1_s})
        else $error("Write accepted for another device address.");
    bulk_head_a: assert property (u_state_reg == U_HEAD && tx_free |=> u_tx_byte_reg == BULK_HEAD)
        else $error("Bulk packet did not start with its header.");

endmodule
`default_nettype wire

//--- verification/dsrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsrp_host (
    input wire logic core_clk,
    input wire logic pin,
    output logic sclk,
    output logic sdi,
    output logic rxd
);
    import dsrp_pkg::*;
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        rxd = 1'b1;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Reads just before the next rise, since the reply lags the rise by a few core cycles.
    task automatic spi(input logic [47:0] tx, input int n, output logic [47:0] rx);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            sdi <= tx[i];
            ticks(4);
            sclk <= 1'b0;
            ticks(3);
            #1 rx[i] = pin;
            ticks(1);
        end
    endtask
    task automatic utx(input logic [7:0] b, input int stop);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            ticks(i < 9 ? int'(DIV_38400) : stop);
        end
    endtask
    task automatic urx(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (pin !== 1'b0 && n < 20000) begin
            ticks(1);
            n++;
        end
        ok = n < 20000;
        ticks(int'(DIV_38400) * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            #1 b[i] = pin;
            ticks(int'(DIV_38400));
        end
    endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsrp_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sel = 1'b1;
    logic cs_a2 = 1'b1;
    logic a1 = 1'b0;
    logic baud = 1'b0;
    logic sclk, sdi, rxd, out, oe, wr, rd, ok;
    logic [7:0] addr, b;
    logic [23:0] wdata, rdata;
    logic [47:0] rx;
    int num_errors = 0;
    int checked = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    wire logic pin = oe ? out : ~out;
    always #20 core_clk = ~core_clk;
    dsrp_port #(.TIMEOUT(20000)) i_dsrp_port (.core_clk(core_clk), .reset(reset),
        .interface_select_strap(sel), .sclk_or_baud_strap(sel ? sclk : baud),
        .rx_or_sdi(sel ? sdi : rxd), .address_high_or_chip_select(cs_a2),
        .address_low_strap(a1), .tx_or_sdo_out(out), .tx_or_sdo_oe(oe), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_wr_strobe(wr), .reg_rd_strobe(rd), .reg_rd_data(rdata));
    dsrp_host i_dsrp_host (.core_clk(core_clk), .pin(pin), .sclk(sclk), .sdi(sdi), .rxd(rxd));
    function automatic logic [23:0] rdval(input logic [7:0] a);
        rdval = {8'h00, a ^ 8'h5A, a}; // Upper byte padded with zeros
    endfunction
    function automatic logic [7:0] sum(input logic [7:0] c, input logic [23:0] d);
        sum = ~(c + d[7:0] + d[15:8] + d[23:16]);
    endfunction
    function automatic logic [47:0] fr(input logic [7:0] id, a, input logic [23:0] d);
        fr = {id, a, d, sum(id + a, d)};
    endfunction
    assign rdata = rdval(addr);
    always @(posedge core_clk) if (wr) wr_cnt++;
    always @(posedge core_clk) if (rd) rd_cnt++;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [23:0] m;
        logic [7:0] ra;
        logic [31:0] e;
        logic [47:0] w;
        void'($urandom(32'hc028));
        m = {14'($urandom), 2'h3, 8'($urandom)};
        ra = {3'h1, 5'($urandom)};
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        cs_a2 <= 1'b0;
        repeat (8) @(posedge core_clk);
        // A corrupted checksum must leave the mode register untouched.
        i_dsrp_host.spi(fr(8'hA8, 8'h19, m) ^ 48'h1, 48, rx);
        i_dsrp_host.spi(fr(8'h58, 8'h19, 24'h0), 48, rx);
        chk({wr_cnt[15:0], rx[31:0]}, {16'h0, 24'h0, sum(8'h71, 24'h0)});
        i_dsrp_host.spi(fr(8'hA8, 8'h19, m), 48, rx);
        repeat (10) @(posedge core_clk);
        chk({wr_cnt[15:0], addr, wdata}, {16'h1, 8'h19, m});
        i_dsrp_host.spi(fr(8'h58, 8'h19, 24'h0), 48, rx);
        chk(rx[31:0], {m, sum(8'h71, m)});
        // Junk leaves the frame misaligned until the run of ones clears it.
        i_dsrp_host.spi(48'h5A5A, 16, rx);
        i_dsrp_host.spi({48{1'b1}}, 48, rx);
        i_dsrp_host.spi(fr(8'h58, ra, 24'h0), 48, rx);
        chk(rx[31:0], {rdval(ra), sum(8'h58 + ra, rdval(ra))});
        repeat (4) @(posedge core_clk);
        chk(oe, 1'b0);
        sel <= 1'b0;
        {cs_a2, a1, baud} <= 3'($urandom);
        repeat (8) @(posedge core_clk);
        i_dsrp_host.utx({6'h16, cs_a2, a1}, int'(DIV_38400));
        i_dsrp_host.utx(8'h19, int'(DIV_38400) / 4);
        e = {sum({6'h16, cs_a2, a1} + 8'h19, m), m};
        for (int i = 0; i < 4; i++) begin
            i_dsrp_host.urx(b, ok);
            chk({ok, b}, {1'b1, e[i * 8 +: 8]});
        end
        // A UART write must land with its data bytes taken least significant first.
        i_dsrp_host.ticks(int'(DIV_38400));
        w = {8'h00, 24'($urandom), 3'h2, 5'($urandom), 6'h2A, cs_a2, a1};
        w[47:40] = sum(w[7:0] + w[15:8], w[39:16]);
        for (int i = 0; i < 6; i++) begin
            i_dsrp_host.utx(w[i * 8 +: 8], int'(DIV_38400));
        end
        repeat (8) @(posedge core_clk);
        chk({wr_cnt[15:0], addr, wdata}, {16'h2, w[15:8], w[39:16]});
        chk(rd_cnt, 4);
        end_of_test();
    end
endmodule
`default_nettype wire
